// File: hw/drrcc_pkg.sv
// Package for the row, read and calibration command block.
// Assumes one clock and a controller on that same clock.
`default_nettype none
package drrcc_pkg;
	// Geometry
	localparam int ADDR_W = 15;
	localparam int BANK_W = 3;
	localparam int NBANKS = 8;
	localparam int DQ_W = 16;
	localparam int COL_W = 10;
	localparam int RL_DEPTH_DEF = 32;
	localparam int PADDR_W = 12;

	// Command codes on the command port
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_ACT = 3'b001,
		CMD_PRE = 3'b010,
		CMD_RD = 3'b011,
		CMD_WR = 3'b100,
		CMD_MRS = 3'b101
	} drrcc_cmd_t;

	// Per-bank state
	typedef enum logic [1:0] {
		BANK_IDLE = 2'b00,
		BANK_ACTIVE = 2'b01,
		BANK_PRECHARGING = 2'b10
	} drrcc_bank_state_t;

	// Address pin positions
	localparam int PIN_NIBBLE = 2;
	localparam int PIN_AUTO_CLOSE = 10;
	localparam int PIN_BURST_CHOP = 12;
	localparam int MR3_ENABLE_BIT = 2;

	// Mode register selection on the bank pins
	localparam logic [2:0] MR_FIRST = 3'h0;
	localparam logic [2:0] MR_THIRD = 3'h3;

	// First mode register burst-mode field and third mode register location field
	localparam logic [1:0] BM_FIXED8 = 2'h0;
	localparam logic [1:0] BM_OTF = 2'h1;
	localparam logic [1:0] BM_FIXED4 = 2'h2;
	localparam logic [1:0] LOC_PATTERN = 2'h0;

	// Burst shapes
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;
	localparam logic [2:0] UPPER_NIBBLE = 3'h4;

	// Register byte offsets
	localparam logic [11:0] REG_LATENCY = 12'h000;
	localparam logic [11:0] REG_PRECHARGE = 12'h004;
	localparam logic [11:0] REG_MODE_STATUS = 12'h008;
	localparam logic [11:0] REG_BANK_STATUS = 12'h00c;
	localparam logic [11:0] REG_ERRORS = 12'h010;

	// Field positions
	localparam int LAT_AL_LSB = 0;
	localparam int LAT_CL_LSB = 8;
	localparam int LAT_W = 5;
	localparam int TRP_W = 8;
	localparam int ERR_W = 16;

	// Reset values
	localparam logic [4:0] RESET_AL = 5'h00;
	localparam logic [4:0] RESET_CL = 5'h06;
	localparam logic [7:0] RESET_TRP = 8'h0e;

	// One entry of the read latency pipe
	typedef struct packed {
		logic vld;
		logic cal;
		logic pat;
		logic chop;
		logic [2:0] start;
		logic [5:0] row;
		logic [6:0] col;
	} drrcc_rd_t;
endpackage
`default_nettype wire

// File: hw/drrcc_bank_if.sv
// Interface between the command decoder and one bank tracker.
// Assumes the decoder drives the strobes for one cycle each.
`timescale 1ns/100ps
`default_nettype none
interface drrcc_bank_if;
	import drrcc_pkg::*;
	logic act;
	logic pre;
	logic [ADDR_W-1:0] row_in;
	logic [TRP_W-1:0] trp;
	drrcc_bank_state_t state;
	logic [ADDR_W-1:0] row;

	modport ctrl (output act, output pre, output row_in, output trp, input state, input row);
	modport bank (input act, input pre, input row_in, input trp, output state, output row);
endinterface
`default_nettype wire

// File: hw/drrcc_bank.sv
// One bank tracker: idle, active with an open row, or precharging.
// Assumes the decoder never activates a bank that is not idle.
`timescale 1ns/100ps
`default_nettype none
module drrcc_bank
	import drrcc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Decoder side
	drrcc_bank_if.bank bus
);
	drrcc_bank_state_t state_q, state_d;
	logic [ADDR_W-1:0] row_q, row_d;
	logic [TRP_W-1:0] cnt_q, cnt_d;

	always_comb begin
		state_d = state_q;
		row_d = row_q;
		cnt_d = cnt_q;
		if (bus.pre) begin
			state_d = BANK_PRECHARGING;
			cnt_d = (bus.trp == '0) ? TRP_W'(1) : bus.trp;
		end else if (bus.act && state_q == BANK_IDLE) begin
			state_d = BANK_ACTIVE;
			row_d = bus.row_in;
		end else begin
			case (state_q)
				BANK_PRECHARGING: begin
					if (cnt_q <= TRP_W'(1)) begin
						state_d = BANK_IDLE;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q - TRP_W'(1);
					end
				end
				BANK_IDLE: ;
				BANK_ACTIVE: ;
				default: state_d = BANK_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= BANK_IDLE;
			row_q <= '0;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			row_q <= row_d;
			cnt_q <= cnt_d;
		end
	end

	assign bus.state = state_q;
	assign bus.row = row_q;
endmodule // drrcc_bank
`default_nettype wire

// File: hw/drrcc_top.sv
// Command-level core: bank tracking, read bursts and calibration readout.
// Assumes the controller runs on pclk and presents one command per cycle.
`timescale 1ns/100ps
`default_nettype none
module drrcc_top
	import drrcc_pkg::*;
#(
	parameter int RL_DEPTH = RL_DEPTH_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Command port
	input wire drrcc_cmd_t cmd_code,
	input wire logic [BANK_W-1:0] cmd_bank,
	input wire logic [ADDR_W-1:0] cmd_addr,
	// Read data
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	output logic rd_valid,
	output logic cmd_refused
);
	// Bank trackers
	drrcc_bank_if bif[NBANKS]();
	drrcc_bank_state_t st [NBANKS];
	logic [ADDR_W-1:0] rows [NBANKS];
	logic [NBANKS-1:0] act_v, pre_v;
	logic [TRP_W-1:0] trp_q, trp_d;

	for (genvar g = 0; g < NBANKS; g++) begin : g_bank
		drrcc_bank u_bank (
			.pclk(pclk),
			.presetn(presetn),
			.bus(bif[g])
		);
		assign bif[g].act = act_v[g];
		assign bif[g].pre = pre_v[g];
		assign bif[g].row_in = cmd_addr;
		assign bif[g].trp = trp_q;
		assign st[g] = bif[g].state;
		assign rows[g] = bif[g].row;
	end

	// Mode state and software registers
	logic cal_en_q, cal_en_d;
	logic [1:0] loc_q, loc_d;
	logic [1:0] bm_q, bm_d;
	logic [LAT_W-1:0] al_q, al_d, cl_q, cl_d;
	logic [ERR_W-1:0] errcnt_q, errcnt_d;
	logic refuse_q, refuse_d;

	// Read pipe and burst state
	drrcc_rd_t pipe_q [RL_DEPTH];
	drrcc_rd_t pipe_d [RL_DEPTH];
	drrcc_rd_t ent_q, ent_d, push, nxt;
	logic [2:0] idx_q, idx_d;
	logic [3:0] left_q, left_d;
	logic [DQ_W-1:0] dq_q, dq_d;
	logic valid_q, valid_d;
	logic [LAT_W:0] rl;
	localparam int RLI_W = $clog2(RL_DEPTH);
	logic [RLI_W-1:0] rl_idx;

	// APB state
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic acc, wr_fire;
	logic any_busy, chop;

	// Command decode
	always_comb begin
		act_v = '0;
		pre_v = '0;
		refuse_d = 1'b0;
		cal_en_d = cal_en_q;
		loc_d = loc_q;
		bm_d = bm_q;
		push = '0;
		any_busy = 1'b0;
		for (int i = 0; i < NBANKS; i++) begin
			any_busy = any_busy | (st[i] != BANK_IDLE);
		end
		case (bm_q)
			BM_OTF: chop = ~cmd_addr[PIN_BURST_CHOP];
			BM_FIXED4: chop = 1'b1;
			default: chop = 1'b0;
		endcase
		push.chop = chop;
		push.start = chop && cmd_addr[PIN_NIBBLE] ? UPPER_NIBBLE : 3'h0;
		push.col = cmd_addr[COL_W-1:3];
		push.row = rows[cmd_bank][5:0];
		case (cmd_code)
			CMD_ACT: begin
				if (cal_en_q || st[cmd_bank] != BANK_IDLE) begin
					refuse_d = 1'b1;
				end else begin
					act_v[cmd_bank] = 1'b1;
				end
			end
			CMD_PRE: begin
				if (cal_en_q) begin
					refuse_d = 1'b1;
				end else if (cmd_addr[PIN_AUTO_CLOSE]) begin
					pre_v = '1;
				end else begin
					pre_v[cmd_bank] = 1'b1;
				end
			end
			CMD_RD: begin
				if (cal_en_q) begin
					push.vld = 1'b1;
					push.cal = 1'b1;
					push.pat = (loc_q == LOC_PATTERN);
				end else if (st[cmd_bank] != BANK_ACTIVE) begin
					refuse_d = 1'b1;
				end else begin
					push.vld = 1'b1;
					pre_v[cmd_bank] = cmd_addr[PIN_AUTO_CLOSE];
				end
			end
			CMD_WR: begin
				if (cal_en_q || st[cmd_bank] != BANK_ACTIVE) begin
					refuse_d = 1'b1;
				end else begin
					pre_v[cmd_bank] = cmd_addr[PIN_AUTO_CLOSE];
				end
			end
			CMD_MRS: begin
				if (cmd_bank == MR_THIRD) begin
					if (cmd_addr[MR3_ENABLE_BIT] && any_busy) begin
						refuse_d = 1'b1;
					end else begin
						cal_en_d = cmd_addr[MR3_ENABLE_BIT];
						loc_d = cmd_addr[1:0];
					end
				end else if (cal_en_q) begin
					refuse_d = 1'b1;
				end else if (cmd_bank == MR_FIRST) begin
					bm_d = cmd_addr[1:0];
				end
			end
			default: ;
		endcase
	end

	always_comb begin
		rl = {1'b0, al_q} + {1'b0, cl_q};
		if (rl == '0) begin
			rl_idx = '0;
		end else if (32'(rl) > RL_DEPTH) begin
			rl_idx = RLI_W'(RL_DEPTH - 1);
		end else begin
			rl_idx = RLI_W'(rl - 1'b1);
		end
	end

	// Read pipe, burst sequencer and data
	always_comb begin
		pipe_d[0] = push;
		for (int i = 1; i < RL_DEPTH; i++) begin
			pipe_d[i] = pipe_q[i-1];
		end
		nxt = pipe_q[rl_idx];
		ent_d = ent_q;
		idx_d = idx_q;
		left_d = left_q;
		// A new burst overrides the tail of the old one; spacing is the controller's job
		if (nxt.vld) begin
			ent_d = nxt;
			idx_d = nxt.start;
			left_d = nxt.chop ? BEATS_CHOP : BEATS_FULL;
		end else if (left_q != '0) begin
			idx_d = idx_q + 3'h1;
			left_d = left_q - 4'h1;
		end
		valid_d = (left_d != '0);
		if (!valid_d) begin
			dq_d = '0;
		// Bit on line zero of each lane
		end else if (ent_d.cal) begin
			dq_d = {7'h00, ent_d.pat & idx_d[0], 7'h00, ent_d.pat & idx_d[0]};
		end else begin
			dq_d = {ent_d.row, ent_d.col, idx_d};
		end
	end

	// APB slave, one wait state
	always_comb begin
		acc = psel & penable & ~pready_q;
		wr_fire = psel & penable & pready_q & pwrite;
		pready_d = acc;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		al_d = al_q;
		cl_d = cl_q;
		trp_d = trp_q;
		errcnt_d = errcnt_q;
		if (acc) begin
			prdata_d = '0;
			case (paddr)
				REG_LATENCY: prdata_d = 32'({cl_q, 3'h0, al_q});
				REG_PRECHARGE: prdata_d = 32'(trp_q);
				REG_MODE_STATUS: prdata_d = 32'({bm_q, loc_q, cal_en_q});
				REG_BANK_STATUS: begin
					for (int i = 0; i < NBANKS; i++) begin
						prdata_d[2*i +: 2] = st[i];
					end
				end
				REG_ERRORS: prdata_d = 32'(errcnt_q);
				default: pslverr_d = 1'b1;
			endcase
		end
		if (wr_fire) begin
			case (paddr)
				REG_LATENCY: begin
					al_d = pwdata[LAT_AL_LSB +: LAT_W];
					cl_d = pwdata[LAT_CL_LSB +: LAT_W];
				end
				REG_PRECHARGE: trp_d = pwdata[TRP_W-1:0];
				REG_ERRORS: errcnt_d = '0;
				default: ;
			endcase
		end
		// A refusal in the clearing cycle still counts
		if (refuse_q && errcnt_d != '1) begin
			errcnt_d = errcnt_d + ERR_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_en_q <= 1'b0;
			loc_q <= '0;
			bm_q <= BM_FIXED8;
			al_q <= RESET_AL;
			cl_q <= RESET_CL;
			trp_q <= RESET_TRP;
			errcnt_q <= '0;
			refuse_q <= 1'b0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			cal_en_q <= cal_en_d;
			loc_q <= loc_d;
			bm_q <= bm_d;
			al_q <= al_d;
			cl_q <= cl_d;
			trp_q <= trp_d;
			errcnt_q <= errcnt_d;
			refuse_q <= refuse_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < RL_DEPTH; i++) begin
				pipe_q[i] <= '0;
			end
			ent_q <= '0;
			idx_q <= '0;
			left_q <= '0;
			dq_q <= '0;
			valid_q <= 1'b0;
		end else begin
			for (int i = 0; i < RL_DEPTH; i++) begin
				pipe_q[i] <= pipe_d[i];
			end
			ent_q <= ent_d;
			idx_q <= idx_d;
			left_q <= left_d;
			dq_q <= dq_d;
			valid_q <= valid_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign dq_out = dq_q;
	assign dq_oe = valid_q;
	assign rd_valid = valid_q;
	assign cmd_refused = refuse_q;
endmodule // drrcc_top
`default_nettype wire

// File: tb/drrcc_asserts.sv
// Checker on the top ports: APB handshake, read beats, refusals.
// Assumes one clock and calibration left only with no burst in flight.
`timescale 1ns/100ps
`default_nettype none
module drrcc_asserts
	import drrcc_pkg::*;
#(
	parameter int RL_DEPTH = RL_DEPTH_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Commands and data
	input wire drrcc_cmd_t cmd_code,
	input wire logic [BANK_W-1:0] cmd_bank,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic rd_valid,
	input wire logic cmd_refused
);
	logic mrs_q, mrs_d, en_q, en_d, cal_q, cal_d, loc0_q, loc0_d, pat_q, pat_d;
	// Mode follows the refusal flag, so a refused enable is not counted
	always_comb begin
		mrs_d = (cmd_code == CMD_MRS) && (cmd_bank == MR_THIRD);
		en_d = cmd_addr[MR3_ENABLE_BIT];
		loc0_d = (cmd_addr[1:0] == LOC_PATTERN);
		cal_d = (mrs_q && !cmd_refused) ? en_q : cal_q;
		pat_d = (mrs_q && !cmd_refused) ? loc0_q : pat_q;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mrs_q <= 1'b0;
			en_q <= 1'b0;
			cal_q <= 1'b0;
			loc0_q <= 1'b0;
			pat_q <= 1'b0;
		end else begin
			mrs_q <= mrs_d;
			en_q <= en_d;
			cal_q <= cal_d;
			loc0_q <= loc0_d;
			pat_q <= pat_d;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_oe_valid: assert property (!rd_valid |-> !dq_oe && dq_out == 16'h0000)
		else $error("data driven outside a burst");
	chk_burst_min: assert property ($rose(dq_oe) |-> dq_oe [*4])
		else $error("burst shorter than four");
	chk_first_even: assert property ($rose(dq_oe) |-> !dq_out[0])
		else $error("burst starts on odd beat");
	// Reserved locations read zero, so only the pattern location must toggle
	chk_lsb_toggle: assert property (dq_oe && $past(dq_oe) && !(cal_q && !pat_q) |-> dq_out[0] != $past(dq_out[0]))
		else $error("pattern bit did not alternate");
	chk_cal_lanes: assert property (cal_q && dq_oe |-> dq_out == {7'h00, dq_out[0], 7'h00, dq_out[0]})
		else $error("lane layout wrong");
	chk_cal_refuse: assert property (cal_q && (cmd_code inside {CMD_WR, CMD_ACT}) |=> cmd_refused)
		else $error("command taken in calibration");
	chk_refuse_cause: assert property (cmd_refused |-> $past(cmd_code) != CMD_NOP)
		else $error("refusal without command");
	chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
		else $error("ready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	cover property ($rose(dq_oe) && cal_q);
	cover property (cmd_refused);
	cover property (pslverr);
endmodule // drrcc_asserts
`default_nettype wire

// File: tb/drrcc_ctl_model.sv
// Controller model: drives command pins, keeps its own waits.
// Assumes pclk is shared with the block.
`timescale 1ns/100ps
`default_nettype none
module drrcc_ctl_model
	import drrcc_pkg::*;
#(
	parameter int T_RP = 14,
	parameter int T_MOD = 12,
	parameter int T_MPRR = 2
) (
	// Clock
	input wire logic pclk,
	// Command pins
	output drrcc_cmd_t cmd_code,
	output logic [BANK_W-1:0] cmd_bank,
	output logic [ADDR_W-1:0] cmd_addr
);
	initial begin
		cmd_code = CMD_NOP;
		cmd_bank = 3'h0;
		cmd_addr = 15'h0000;
	end
	// Caller gives the wait after each command
	task automatic send(input drrcc_cmd_t c, input logic [2:0] b, input logic [14:0] a, input int gap);
		@(posedge pclk);
		cmd_code <= c;
		cmd_bank <= b;
		cmd_addr <= a;
		@(posedge pclk);
		cmd_code <= CMD_NOP;
		// Released pins flip so stale values never look valid
		cmd_bank <= ~b;
		cmd_addr <= ~a;
		repeat (gap) @(posedge pclk);
	endtask
	// Close all banks, wait out the precharge
	// Mode delays before any calibration read
	task automatic cal_enter();
		send(CMD_PRE, 3'h0, 15'h0400, T_RP);
		send(CMD_MRS, MR_THIRD, 15'h0004, T_MOD);
	endtask
	task automatic cal_exit();
		repeat (T_MPRR) @(posedge pclk);
		send(CMD_MRS, MR_THIRD, 15'h0003, T_MOD);
	endtask
endmodule // drrcc_ctl_model
`default_nettype wire

// File: tb/tb.sv
// Top bench: register table, bank states, bursts, calibration.
// Assumes the controller model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb
	import drrcc_pkg::*;
;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} drrcc_tb_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, dq_oe, rd_valid, cmd_refused;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	drrcc_cmd_t cmd_code;
	logic [2:0] cmd_bank;
	logic [14:0] cmd_addr;
	logic [15:0] dq_out;
	int n_errors = 0;
	int checked = 0;
	drrcc_tb_row_t rows [7] = '{'{REG_LATENCY, 32'h0000_0600, 1'b0}, '{REG_PRECHARGE, 32'h0000_000e, 1'b0},
		'{REG_MODE_STATUS, 32'h0, 1'b0}, '{REG_BANK_STATUS, 32'h0, 1'b0}, '{REG_ERRORS, 32'h0, 1'b0},
		'{12'h014, 32'h0, 1'b1}, '{12'h002, 32'h0, 1'b1}};
	drrcc_top #(.RL_DEPTH(32)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .rd_valid(rd_valid), .cmd_refused(cmd_refused));
	drrcc_ctl_model i_ctl (.pclk(pclk), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Checks quiet before, each beat, quiet after
	task automatic burst(input int rl, input int n, input logic [15:0] first, input logic cal);
		logic [15:0] e;
		e = first;
		repeat (rl - 1) @(posedge pclk);
		#1 check(dq_oe, 1'b0);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			#1 check(dq_oe, 1'b1);
			check(rd_valid, 1'b1);
			check(dq_out, e);
			e = cal ? e ^ 16'h0101 : e + 16'h0001;
		end
		@(posedge pclk);
		#1 check(dq_oe, 1'b0);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			check(rd, rows[i].d);
			check(er, rows[i].e);
		end
		apb(1'b1, REG_PRECHARGE, 32'h0000_0005);
		apb(1'b0, REG_PRECHARGE, 32'h0);
		check(rd, 32'h0000_0005);
		i_ctl.send(CMD_ACT, 3'h2, 15'h002b, 2);
		i_ctl.send(CMD_ACT, 3'h2, 15'h0011, 0);
		#1 check(cmd_refused, 1'b1);
		repeat (2) @(posedge pclk);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0000_0010);
		i_ctl.send(CMD_RD, 3'h2, 15'h00a8, 0);
		burst(6, 8, 16'hac_a8, 1'b0);
		i_ctl.send(CMD_MRS, MR_FIRST, 15'h0001, 4);
		i_ctl.send(CMD_RD, 3'h2, 15'h00ac, 0);
		burst(6, 4, 16'hac_ac, 1'b0);
		i_ctl.send(CMD_RD, 3'h2, 15'h10a8, 0);
		burst(6, 8, 16'hac_a8, 1'b0);
		i_ctl.send(CMD_RD, 3'h5, 15'h1000, 2);
		apb(1'b0, REG_ERRORS, 32'h0);
		check(rd, 32'h0000_0002);
		i_ctl.send(CMD_PRE, 3'h2, 15'h0000, 3);
		i_ctl.send(CMD_PRE, 3'h2, 15'h0000, 0);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0000_0020);
		repeat (12) @(posedge pclk);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, REG_ERRORS, 32'h0);
		i_ctl.cal_enter();
		apb(1'b0, REG_MODE_STATUS, 32'h0);
		check(rd, 32'h0000_0009);
		i_ctl.send(CMD_RD, 3'h5, 15'h1000, 0);
		burst(6, 8, 16'h0, 1'b1);
		i_ctl.send(CMD_RD, 3'h1, 15'h0004, 0);
		burst(6, 4, 16'h0, 1'b1);
		i_ctl.send(CMD_RD, 3'h3, 15'h1400, 0);
		burst(6, 8, 16'h0, 1'b1);
		i_ctl.send(CMD_WR, 3'h0, 15'h1000, 2);
		i_ctl.send(CMD_ACT, 3'h0, 15'h0000, 2);
		apb(1'b0, REG_ERRORS, 32'h0);
		check(rd, 32'h0000_0002);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0);
		i_ctl.cal_exit();
		i_ctl.send(CMD_ACT, 3'h0, 15'h0041, 2);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0000_0001);
		apb(1'b1, REG_LATENCY, 32'h0000_0602);
		i_ctl.send(CMD_RD, 3'h0, 15'h1000, 0);
		burst(8, 8, 16'h0400, 1'b0);
		i_ctl.send(CMD_MRS, MR_FIRST, 15'h0002, 4);
		i_ctl.send(CMD_RD, 3'h0, 15'h1400, 0);
		burst(8, 4, 16'h0400, 1'b0);
		apb(1'b0, REG_BANK_STATUS, 32'h0);
		check(rd, 32'h0);
		// Mid-run reset must restore the latency, mode status and error registers
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1 check(dq_oe, 1'b0);
		check(cmd_refused, 1'b0);
		apb(1'b0, REG_LATENCY, 32'h0);
		check(rd, 32'h0000_0600);
		apb(1'b0, REG_MODE_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, REG_ERRORS, 32'h0);
		check(rd, 32'h0);
		report_and_stop();
	end
endmodule // tb
bind drrcc_top drrcc_asserts #(.RL_DEPTH(RL_DEPTH)) i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
	.dq_out(dq_out), .dq_oe(dq_oe), .rd_valid(rd_valid), .cmd_refused(cmd_refused));
`default_nettype wire
